// ---- rtl/ursh_uart.sv ----
`timescale 1ns/10ps
`include "ursh_regs.svh"
module ursh_uart #(
    parameter int DATA_W     = `URSH_DATA_W,
    parameter int FIFO_DEPTH = `URSH_FIFO_DEPTH
) (
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              baud16_en_in,
    input  wire logic              parity_enable_in,
    input  wire logic              parity_odd_in,
    input  wire logic              infrared_select_in,
    input  wire logic              rx_pin_in,
    input  wire logic              status_read_in,
    input  wire logic              buffer_read_in,
    input  wire logic [DATA_W-1:0] tx_data_in,
    input  wire logic              tx_valid_in,
    output logic                   tx_ready_out,
    output logic [3:0]             serial_status_reg_out,
    output logic [DATA_W-1:0]      rx_holding_buffer_out,
    output logic                   rx_interrupt_request_out,
    output logic                   serial_tx_pin_out
);
    ////////////////////////////////////////////////////////////////////
    // Receive framer
    ursh_pkg::ursh_rx_state_type rx_state_reg;
    ursh_pkg::ursh_rx_state_type rx_state_next;
    logic [3:0]        rx_tick_reg;
    logic [3:0]        rx_tick_next;
    logic [3:0]        rx_bit_reg;
    logic [3:0]        rx_bit_next;
    logic [DATA_W-1:0] rx_shift_reg;
    logic [DATA_W-1:0] rx_shift_next;
    logic              rx_par_reg;
    logic              rx_par_next;
    logic              rx_done;
    logic              rx_framing_error_flag;
    logic              rx_parity_error_flag;
    logic [3:0]        rx_bits_total;

    always_comb
    begin
        rx_state_next = rx_state_reg;
        rx_tick_next  = rx_tick_reg;
        rx_bit_next   = rx_bit_reg;
        rx_shift_next = rx_shift_reg;
        rx_par_next   = rx_par_reg;
        rx_done       = 1'b0;
        rx_framing_error_flag       = 1'b0;
        rx_parity_error_flag       = 1'b0;
        rx_bits_total = 4'(DATA_W) + 4'(parity_enable_in);
        if (baud16_en_in)
        begin
            unique case (rx_state_reg)
                ursh_pkg::URSH_IDLE_TYPE:
                    if (!rx_pin_in)
                    begin
                        rx_state_next = ursh_pkg::URSH_START_TYPE;
                        rx_tick_next  = '0;
                    end
                ursh_pkg::URSH_START_TYPE:
                begin
                    rx_tick_next = rx_tick_reg + 4'h1;
                    if (rx_tick_reg == 4'(`URSH_OVS/2 - 1))
                    begin
                        rx_tick_next  = '0;
                        rx_bit_next   = '0;
                        rx_state_next = rx_pin_in ? ursh_pkg::URSH_IDLE_TYPE
                                                  : ursh_pkg::URSH_DATA_TYPE;
                    end
                end
                ursh_pkg::URSH_DATA_TYPE:
                begin
                    rx_tick_next = rx_tick_reg + 4'h1;
                    if (rx_tick_reg == 4'(`URSH_OVS - 1))
                    begin
                        rx_bit_next = rx_bit_reg + 4'h1;
                        if (rx_bit_reg < 4'(DATA_W))
                            rx_shift_next = {rx_pin_in, rx_shift_reg[DATA_W-1:1]};
                        else
                            rx_par_next = rx_pin_in;
                        if (rx_bit_reg == rx_bits_total - 4'h1)
                            rx_state_next = ursh_pkg::URSH_STOP_TYPE;
                    end
                end
                ursh_pkg::URSH_STOP_TYPE:
                begin
                    rx_tick_next = rx_tick_reg + 4'h1;
                    if (rx_tick_reg == 4'(`URSH_OVS - 1))
                    begin
                        rx_done       = 1'b1;
                        rx_framing_error_flag       = !rx_pin_in;
                        rx_parity_error_flag       = parity_enable_in &&
                                        ((^rx_shift_reg ^ rx_par_reg) != parity_odd_in);
                        rx_state_next = ursh_pkg::URSH_IDLE_TYPE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            rx_state_reg <= ursh_pkg::URSH_IDLE_TYPE;
            rx_tick_reg  <= '0;
            rx_bit_reg   <= '0;
            rx_shift_reg <= '0;
            rx_par_reg   <= 1'b0;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            rx_tick_reg  <= rx_tick_next;
            rx_bit_reg   <= rx_bit_next;
            rx_shift_reg <= rx_shift_next;
            rx_par_reg   <= rx_par_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status flags and holding buffer
    logic [3:0]        stat_reg;
    logic [3:0]        stat_next;
    logic [3:0]        seen_reg;
    logic [3:0]        seen_next;
    logic [DATA_W-1:0] hold_reg;
    logic [DATA_W-1:0] hold_next;
    logic              irq_reg;
    logic              irq_next;
    logic              load;
    logic              ovr;

    always_comb
    begin
        stat_next = stat_reg;
        seen_next = seen_reg;
        hold_next = hold_reg;
        // R10: seen flags cleared
        if (status_read_in)
            seen_next = stat_reg;
        if (buffer_read_in)
        begin
            stat_next = stat_reg & ~seen_reg;
            seen_next = '0;
        end
        // R11: discard while still full
        ovr  = rx_done && stat_reg[`URSH_STAT_FULL] && !(buffer_read_in
               && seen_reg[`URSH_STAT_FULL]);
        load = rx_done && !ovr;
        // R13: load sets full
        if (load)
        begin
            hold_next                    = rx_shift_reg;
            stat_next[`URSH_STAT_FULL]   = 1'b1;
            // R1: flags describe held char
            stat_next[`URSH_STAT_FRAMING_ERROR_FLAG]   = rx_framing_error_flag;
            stat_next[`URSH_STAT_PARITY_ERROR_FLAG]   = rx_parity_error_flag;
        end
        // R2: overrun sticky, no count
        if (ovr)
            stat_next[`URSH_STAT_OVERRUN_ERROR_FLAG] = 1'b1;
        // R13: request on load or new overrun
        // R11: no request for a repeat overrun while overrun set
        irq_next = load || (ovr && !stat_reg[`URSH_STAT_OVERRUN_ERROR_FLAG]);
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            stat_reg <= `URSH_STAT_RESET;
            seen_reg <= '0;
            hold_reg <= '0;
            irq_reg  <= 1'b0;
        end
        else
        begin
            stat_reg <= stat_next;
            seen_reg <= seen_next;
            hold_reg <= hold_next;
            irq_reg  <= irq_next;
        end
    end

    // R3: R4: R5: R6: flags reported separately
    assign serial_status_reg_out    = stat_reg;
    assign rx_holding_buffer_out    = hold_reg;
    assign rx_interrupt_request_out = irq_reg;

    // R12: discarded errors never set flags
    chk_discard_keeps_err: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R12
        ovr |=> stat_reg[`URSH_STAT_FRAMING_ERROR_FLAG] == $past(stat_reg[`URSH_STAT_FRAMING_ERROR_FLAG])
             && hold_reg == $past(hold_reg))
        else $error("discarded character changed buffer or error flag");
    chk_overrun_silent: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R11
        (ovr && stat_reg[`URSH_STAT_OVERRUN_ERROR_FLAG]) |=> !irq_reg)
        else $error("request raised while overrun set");
    chk_load_sets_full: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R13
        load |=> stat_reg[`URSH_STAT_FULL] && irq_reg)
        else $error("load did not set full and request");
    sequence s_status_then_read;
        status_read_in && !buffer_read_in && !rx_done ##1 buffer_read_in && !rx_done;
    endsequence
    chk_seen_cleared: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R10
        s_status_then_read |=> (stat_reg & $past(stat_reg, 2)) == 4'h0)
        else $error("seen flag survived buffer read");
    chk_irq_full: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R6
        (irq_reg && !$past(ovr)) |-> stat_reg[`URSH_STAT_FULL])
        else $error("request without a character");

    ////////////////////////////////////////////////////////////////////
    // Transmit path with FIFO and infrared pulse
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid;
    logic              fifo_pop;
    ursh_pkg::ursh_tx_state_type tx_state_reg;
    ursh_pkg::ursh_tx_state_type tx_state_next;
    logic [3:0]        tx_tick_reg;
    logic [3:0]        tx_tick_next;
    logic [3:0]        tx_bit_reg;
    logic [3:0]        tx_bit_next;
    logic [DATA_W+1:0] tx_frame_reg;
    logic [DATA_W+1:0] tx_frame_next;
    logic              tx_level;
    logic              pin_reg;
    logic              pin_next;

    ursh_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in       (clk_in),
        .sys_rst_in   (sys_rst_in),
        .wr_data_in   (tx_data_in),
        .wr_valid_in  (tx_valid_in),
        .wr_ready_out (tx_ready_out),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (fifo_pop)
    );

    always_comb
    begin
        tx_state_next = tx_state_reg;
        tx_tick_next  = tx_tick_reg;
        tx_bit_next   = tx_bit_reg;
        tx_frame_next = tx_frame_reg;
        fifo_pop      = 1'b0;
        unique case (tx_state_reg)
            ursh_pkg::URSH_TX_IDLE_TYPE:
                if (fifo_valid && baud16_en_in)
                begin
                    fifo_pop      = 1'b1;
                    tx_frame_next = {1'b1, fifo_data, 1'b0};
                    tx_tick_next  = '0;
                    tx_bit_next   = '0;
                    tx_state_next = ursh_pkg::URSH_TX_BIT_TYPE;
                end
            ursh_pkg::URSH_TX_BIT_TYPE, ursh_pkg::URSH_TX_STOP_TYPE:
                if (baud16_en_in)
                begin
                    tx_tick_next = tx_tick_reg + 4'h1;
                    if (tx_tick_reg == 4'(`URSH_OVS - 1))
                    begin
                        tx_frame_next = {1'b1, tx_frame_reg[DATA_W+1:1]};
                        tx_bit_next   = tx_bit_reg + 4'h1;
                        if (tx_bit_reg == 4'(DATA_W + 1))
                            tx_state_next = ursh_pkg::URSH_TX_IDLE_TYPE;
                    end
                end
            default:
                tx_state_next = ursh_pkg::URSH_TX_IDLE_TYPE;
        endcase
        tx_level = tx_frame_reg[0] || (tx_state_reg == ursh_pkg::URSH_TX_IDLE_TYPE);
        // R9: pulse three sixteenths per zero bit
        if (infrared_select_in)
            pin_next = !tx_level && (tx_state_reg != ursh_pkg::URSH_TX_IDLE_TYPE)
                       && (tx_tick_reg < 4'(`URSH_IR_SIXTEENTHS));
        else
            pin_next = tx_level;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            tx_state_reg <= ursh_pkg::URSH_TX_IDLE_TYPE;
            tx_tick_reg  <= '0;
            tx_bit_reg   <= '0;
            tx_frame_reg <= '1;
            pin_reg      <= 1'b1;
        end
        else
        begin
            tx_state_reg <= tx_state_next;
            tx_tick_reg  <= tx_tick_next;
            tx_bit_reg   <= tx_bit_next;
            tx_frame_reg <= tx_frame_next;
            pin_reg      <= pin_next;
        end
    end

    assign serial_tx_pin_out = pin_reg;

    chk_ir_pulse_width: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R9
        (infrared_select_in && pin_reg) |-> tx_tick_reg <= 4'(`URSH_IR_SIXTEENTHS))
        else $error("infrared pulse too long");
endmodule : ursh_uart

// ---- include/ursh_regs.svh ----
`ifndef URSH_REGS_SVH
`define URSH_REGS_SVH
// Contract
// R1: Error flags mark only the held character
// R2: Overrun means characters lost, no count
// R3: Full 0, overrun 0: nothing new yet
// R4: Full 0, overrun 1: lost during sequence
// R5: Overrun reported apart from error flags
// R6: Interrupt implies a character is present
// R7: Software resends transfer after overrun
// R8: Nested interrupts wait for both reads
// R9: Infrared pulse lasts three sixteenths bit
// R10: Status then buffer read clears seen flags
// R11: Overrun discards new character, no interrupt; the code raises one for the first overrun, none while overrun is set
// R12: Discarded characters never set error flags
// R13: Load sets full; errors raise interrupt
`define URSH_DATA_W       8
`define URSH_FIFO_DEPTH   8
`define URSH_OVS          16
`define URSH_IR_SIXTEENTHS 3
`define URSH_STAT_FULL    0
`define URSH_STAT_FRAMING_ERROR_FLAG    1
`define URSH_STAT_PARITY_ERROR_FLAG    2
`define URSH_STAT_OVERRUN_ERROR_FLAG    3
`define URSH_STAT_RESET   4'h0
`endif

// ---- include/ursh_pkg.sv ----
package ursh_pkg;
    typedef enum logic [1:0] {
        URSH_IDLE_TYPE  = 2'b00,
        URSH_START_TYPE = 2'b01,
        URSH_DATA_TYPE  = 2'b10,
        URSH_STOP_TYPE  = 2'b11
    } ursh_rx_state_type;
    typedef enum logic [1:0] {
        URSH_TX_IDLE_TYPE = 2'b00,
        URSH_TX_BIT_TYPE  = 2'b01,
        URSH_TX_STOP_TYPE = 2'b10
    } ursh_tx_state_type;
endpackage : ursh_pkg

// ---- rtl/ursh_fifo.sv ----
`timescale 1ns/10ps
module ursh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wptr_reg;
    logic [AW-1:0]    wptr_next;
    logic [AW-1:0]    rptr_reg;
    logic [AW-1:0]    rptr_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             do_wr;
    logic             do_rd;
    logic             ready_reg;
    logic             ready_next;

    always_comb
    begin
        do_wr     = wr_valid_in && (cnt_reg != (AW+1)'(DEPTH));
        do_rd     = rd_ready_in && (cnt_reg != '0);
        wptr_next = do_wr ? ((wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1) : wptr_reg;
        rptr_next = do_rd ? ((rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1) : rptr_reg;
        cnt_next  = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        // Ready registered so the top output comes from a flop
        ready_next = (cnt_next != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg  <= '0;
            ready_reg <= 1'b1;
        end
        else
        begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg  <= cnt_next;
            ready_reg <= ready_next;
        end
        if (do_wr)
            mem_reg[wptr_reg] <= wr_data_in;
    end

    assign wr_ready_out = ready_reg;
    assign rd_valid_out = (cnt_reg != '0);
    assign rd_data_out  = mem_reg[rptr_reg];
endmodule : ursh_fifo

// ---- test/ursh_remote_tx.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module ursh_remote_tx (
    input  wire logic       clk_in,
    input  wire logic       tick_in,
    input  wire logic       send_in,
    input  wire logic [7:0] data_in,
    input  wire logic       par_en_in,
    input  wire logic       par_odd_in,
    input  wire logic       bad_par_in,
    input  wire logic       bad_stop_in,
    output logic            line_out,
    output logic            busy_out
);
    logic [10:0] frame_reg = 11'h7ff;
    logic [3:0]  left_reg  = 4'h0;
    logic [3:0]  tick_reg  = 4'h0;
    logic        line_reg  = 1'h1;
    logic        busy_reg  = 1'h0;
    logic        par_bit;
    assign par_bit  = ^data_in ^ par_odd_in ^ bad_par_in;
    assign line_out = line_reg;
    assign busy_out = busy_reg;
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in)
    begin
        if (send_in && !busy_reg)
        begin
            // Start, data LSB first, optional parity, stop
            frame_reg <= par_en_in ? {~bad_stop_in, par_bit, data_in, 1'h0}
                                   : {1'h1, ~bad_stop_in, data_in, 1'h0};
            left_reg  <= par_en_in ? 4'hb : 4'ha;
            tick_reg  <= 4'h0;
            busy_reg  <= 1'h1;
        end
        else if (busy_reg && tick_in)
        begin
            if (tick_reg == 4'h0)
            begin
                line_reg  <= frame_reg[0];
                frame_reg <= frame_reg >> 1;
                left_reg  <= left_reg - 4'h1;
            end
            tick_reg <= tick_reg + 4'h1;
            // Line back to idle high after the stop bit
            if (tick_reg == 4'hf && left_reg == 4'h0)
            begin
                busy_reg <= 1'h0;
                line_reg <= 1'h1;
            end
        end
    end
endmodule : ursh_remote_tx

// ---- test/ursh_uart_test.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module ursh_uart_test;
    localparam int TICK = 2;
    typedef struct packed {logic [3:0] st; logic [7:0] dat;} ursh_note_type;
    logic          clk_in      = 1'h0;
    logic          sys_rst_in  = 1'h1;
    logic          baud16_en   = 1'h0;
    logic          par_en      = 1'h0;
    logic          par_odd     = 1'h0;
    logic          status_read = 1'h0;
    logic          buffer_read = 1'h0;
    logic [7:0]    tx_data     = 8'h00;
    logic          tx_valid    = 1'h0;
    logic          send        = 1'h0;
    logic [7:0]    send_data   = 8'h00;
    logic          bad_par     = 1'h0;
    logic          bad_stop    = 1'h0;
    logic          ir_watch    = 1'h0;
    logic          ir_sel      = 1'h0;
    logic [15:0]   lfsr        = 16'haabe;
    logic          rx_line;
    logic          rem_busy;
    logic          tx_ready;
    logic          irq;
    logic          tx_pin;
    logic [3:0]    status;
    logic [7:0]    holding;
    logic [3:0]    modes [6]   = '{4'h0, 4'h8, 4'hc, 4'ha, 4'he, 4'h1};
    int            err_count   = 0;
    int            check_count = 0;
    int            hi_len      = 0;
    int            pulses      = 0;
    ursh_note_type notes [$];
    ursh_note_type head;
    ursh_uart #(.DATA_W(8), .FIFO_DEPTH(8)) i_ursh_uart (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .baud16_en_in(baud16_en),
        .parity_enable_in(par_en), .parity_odd_in(par_odd), .infrared_select_in(ir_sel),
        .rx_pin_in(rx_line), .status_read_in(status_read), .buffer_read_in(buffer_read),
        .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .serial_status_reg_out(status), .rx_holding_buffer_out(holding),
        .rx_interrupt_request_out(irq), .serial_tx_pin_out(tx_pin));
    ursh_remote_tx i_ursh_remote_tx (
        .clk_in(clk_in), .tick_in(baud16_en), .send_in(send), .data_in(send_data),
        .par_en_in(par_en), .par_odd_in(par_odd), .bad_par_in(bad_par),
        .bad_stop_in(bad_stop), .line_out(rx_line), .busy_out(rem_busy));
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) baud16_en <= ~baud16_en;
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("Mismatches %0d, comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    // One character from the far side; a note is kept when an irq is due
    task automatic send_char(input logic [7:0] d, input logic bp, input logic bs,
                             input logic due, input logic [3:0] st, input logic [7:0] hb);
        int i;
        i = 0;
        if (due)
            notes.push_back({st, hb});
        @(posedge clk_in);
        send      <= 1'h1;
        send_data <= d;
        bad_par   <= bp;
        bad_stop  <= bs;
        @(posedge clk_in);
        send <= 1'h0;
        #1;
        while (rem_busy === 1'h1 && i < 2000)
        begin
            @(posedge clk_in);
            i++;
        end
    endtask : send_char
    task automatic strobe(input logic st, input logic bf);
        @(posedge clk_in);
        status_read <= st;
        buffer_read <= bf;
        @(posedge clk_in);
        status_read <= 1'h0;
        buffer_read <= 1'h0;
    endtask : strobe
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in)
    begin
        if (!sys_rst_in && irq === 1'h1)
        begin
            if (notes.size() == 0)
                check("rx irq unexpected", 12'h001, 12'h000);
            else
            begin
                head = notes.pop_front();
                check("rx status and data", {status, holding}, head);
            end
        end
        if (ir_watch && tx_pin === 1'h1)
            hi_len <= hi_len + 1;
        else if (ir_watch && hi_len != 0)
        begin
            check("ir pulse width", 12'(hi_len), 12'(3 * TICK));
            pulses <= pulses + 1;
            hi_len <= 0;
        end
    end
    initial
    begin
        repeat (30000) @(posedge clk_in);
        err_count++;
        end_sim();
    end
    initial
    begin
        int n;
        int exp_pulses;
        logic [7:0] a;
        n = 0;
        exp_pulses = 0;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        @(posedge clk_in);
        #1;
        check("status idle", {8'h00, status}, 12'h000);
        for (int m = 0; m < 6; m++)
        begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk_in);
            par_en  <= modes[m][3];
            par_odd <= modes[m][2];
            send_char(lfsr[7:0], modes[m][1], modes[m][0], 1'h1,
                      {1'h0, modes[m][3] & modes[m][1], modes[m][0], 1'h1}, lfsr[7:0]);
            strobe(1'h1, 1'h0);
            strobe(1'h0, 1'h1);
            #1;
            check("status cleared", {8'h00, status}, 12'h000);
        end
        // Overrun: held character kept, first overrun raises irq, third arrival silent
        a = lfsr[15:8];
        send_char(a, 1'h0, 1'h0, 1'h1, 4'h1, a);
        send_char(~a, 1'h0, 1'h1, 1'h1, 4'h9, a);
        send_char(8'h5a, 1'h0, 1'h0, 1'h0, 4'h0, a);
        #1;
        check("overrun status and data", {status, holding}, {4'h9, a});
        strobe(1'h1, 1'h0);
        strobe(1'h0, 1'h1);
        #1;
        check("overrun cleared", {8'h00, status}, 12'h000);
        // Arrival between status read and buffer read
        // resend after overrun
        send_char(a, 1'h0, 1'h0, 1'h1, 4'h1, a);
        strobe(1'h1, 1'h0);
        send_char(8'h3c, 1'h0, 1'h0, 1'h1, 4'h9, a);
        strobe(1'h0, 1'h1);
        #1;
        check("late overrun survives", {8'h00, status}, 12'h008);
        strobe(1'h1, 1'h0);
        strobe(1'h0, 1'h1);
        #1;
        check("late overrun cleared", {8'h00, status}, 12'h000);
        check("tx idle level", {11'h000, tx_pin}, 12'h001);
        // Transmit FIFO filled until refusal, drained as infrared pulses
        @(posedge clk_in);
        ir_sel <= 1'h1;
        repeat (2) @(posedge clk_in);
        #1;
        check("ir idle level", {11'h000, tx_pin}, 12'h000);
        ir_watch = 1'h1;
        for (int k = 0; k < 20; k++)
        begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk_in);
            tx_valid <= 1'h1;
            tx_data  <= lfsr[7:0];
            @(negedge clk_in);
            if (tx_ready !== 1'h1)
                break;
            n++;
            exp_pulses += 1 + $countones(~lfsr[7:0]);
        end
        // Refused word held until taken
        exp_pulses += 1 + $countones(~lfsr[7:0]);
        do
        begin
            @(negedge clk_in);
        end
        while (tx_ready !== 1'h1);
        @(posedge clk_in);
        tx_valid <= 1'h0;
        check("tx writes before refusal", 12'(n), 12'h009);
        for (int i = 0; i < 20000 && pulses < exp_pulses; i++)
            @(posedge clk_in);
        repeat (40) @(posedge clk_in);
        check("ir pulse count", 12'(pulses), 12'(exp_pulses));
        check("no notes left", 12'(notes.size()), 12'h000);
        end_sim();
    end
endmodule : ursh_uart_test
